//--- brc_pkg.sv
package brc_pkg;
	// Bridges and register bus
	localparam int BRC_NB = 2;
	localparam int BRC_AW = 5;
	localparam int BRC_DW = 32;
	localparam logic [4:0] BRC_OFS_CTRL_A = 5'h00;
	localparam logic [4:0] BRC_OFS_CTRL_B = 5'h04;
	localparam logic [4:0] BRC_OFS_STAT_A = 5'h08;
	localparam logic [4:0] BRC_OFS_STAT_B = 5'h0c;
	localparam logic [4:0] BRC_OFS_GLOBAL = 5'h10;

	// Control word fields
	localparam int BRC_CT_SDLY_LSB = 0;
	localparam int BRC_CT_FDLY_LSB = 4;
	localparam int BRC_CT_SSS = 8;
	localparam int BRC_CT_PWR = 9;
	localparam int BRC_CT_SET = 10;
	localparam int BRC_CT_MODE_LSB = 11;
	localparam int BRC_DLY_FIELD_W = 4;

	// Status word fields
	localparam int BRC_ST_SCF_LSB = 0;
	localparam int BRC_ST_CONV66 = 8;
	localparam int BRC_ST_HP = 9;
	localparam int BRC_ST_MODE_LSB = 10;
	localparam int BRC_ST_INRST = 15;

	// Global word fields
	localparam int BRC_GL_CAL_LSB = 0;
	localparam int BRC_GL_HPSTRAP = 8;
	localparam int BRC_GL_HPB_EN = 9;
	localparam int BRC_GL_LRA_LSB = 10;
	localparam int BRC_GL_LRB_LSB = 14;

	// Reset values
	localparam logic [3:0] BRC_RST_DLY = 4'h0;
	localparam logic [3:0] BRC_RST_LRATE = 4'h0;
	localparam logic [4:0] BRC_RST_STRAP = 5'h00;

	// Strap encodings
	localparam logic [1:0] BRC_CAP_GND = 2'h0;
	localparam logic [1:0] BRC_CAP_MID = 2'h1;
	localparam logic [1:0] BRC_GNT_133 = 2'h0;

	// Bus modes
	typedef enum logic [4:0] {
		BRC_M_C33 = 5'h01,
		BRC_M_C66 = 5'h02,
		BRC_M_X66 = 5'h04,
		BRC_M_X100 = 5'h08,
		BRC_M_X133 = 5'h10
	} brc_mode_t;

	// Request/grant/clock sets
	localparam logic [4:0] BRC_SETS_5 = 5'h1f;
	localparam logic [4:0] BRC_SETS_4 = 5'h0f;
	localparam logic [4:0] BRC_SETS_3 = 5'h07;

	// Reset sequencing states
	typedef enum logic [2:0] {
		BRC_ST_COLD = 3'h1,
		BRC_ST_WARM = 3'h2,
		BRC_ST_RUN = 3'h4
	} brc_state_t;

	// Timing
	localparam int BRC_CLK_KHZ = 200000;
	localparam int BRC_PG_STABLE_CYC = 6;
	localparam int BRC_NCO_W = 16;
	localparam int BRC_F33_KHZ = 33333;
	localparam int BRC_F66_KHZ = 66667;
	localparam int BRC_F100_KHZ = 100000;
	localparam int BRC_F133_KHZ = 133333;
	localparam int BRC_FFB_KHZ = 66000;
	localparam logic [15:0] BRC_INC_33 = 16'((64'(BRC_F33_KHZ) << 16) / BRC_CLK_KHZ);
	localparam logic [15:0] BRC_INC_66 = 16'((64'(BRC_F66_KHZ) << 16) / BRC_CLK_KHZ);
	localparam logic [15:0] BRC_INC_100 = 16'((64'(BRC_F100_KHZ) << 16) / BRC_CLK_KHZ);
	localparam logic [15:0] BRC_INC_133 = 16'((64'(BRC_F133_KHZ) << 16) / BRC_CLK_KHZ);
	localparam logic [15:0] BRC_INC_FB = 16'((64'(BRC_FFB_KHZ) << 16) / BRC_CLK_KHZ);
endpackage

//--- brc_deglitch.sv
module brc_deglitch
	import brc_pkg::*;
#(
	parameter int STABLE = BRC_PG_STABLE_CYC
)(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Level
	input wire logic d_i,
	output logic q_o
);
	localparam int CW = $clog2(STABLE + 2);
	localparam logic [CW-1:0] LIMIT = CW'(STABLE + 1);
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	wire cnt_full = (cnt_ff == LIMIT);

	if (STABLE < 1)
	begin : g_chk
		$error("brc_deglitch: STABLE must be at least 1");
	end

	// Only the rising edge is filtered; a drop acts at once
	assign nxt_cnt = !d_i ? '0 : (cnt_full ? cnt_ff : cnt_ff + CW'(1));

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_ff <= '0;
			q_o <= 1'b0;
		end
		else if (ce_i)
		begin
			cnt_ff <= nxt_cnt;
			q_o <= d_i && (nxt_cnt == LIMIT);
		end
	end

	AST_PG_RISE: assert property (@(posedge clk_i) disable iff (!rst_n_i || !ce_i) $rose(q_o) |-> $past(d_i, 1) && $past(d_i, 6)) else $error("good rose too early");
	AST_PG_FALL: assert property (@(posedge clk_i) disable iff (!rst_n_i || !ce_i) !d_i |=> !q_o) else $error("good did not drop");
endmodule

//--- brc_tick_delay.sv
module brc_tick_delay #(
	parameter int W = 4
)(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Delay select and tick
	input wire logic [W-1:0] sel_i,
	input wire logic d_i,
	output logic q_o
);
	localparam int DEPTH = (1 << W) - 1;
	logic [DEPTH-1:0] sh_ff;
	wire [DEPTH:0] taps = {sh_ff, d_i};

	if (W < 1 || W > 8)
	begin : g_chk
		$error("brc_tick_delay: W out of range");
	end

	// One clock of delay per increment
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sh_ff <= '0;
			q_o <= 1'b0;
		end
		else if (ce_i)
		begin
			// Slice of taps keeps a one-stage line legal
			sh_ff <= taps[DEPTH-1:0];
			q_o <= taps[sel_i];
		end
	end

	AST_DLY_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i || !ce_i) (sel_i == '0) && d_i |=> q_o) else $error("zero delay lost tick");
endmodule

//--- brc_bridge_reset_clock.sv
// Chosen here: the register offsets and the address-and-strobe port.
module brc_bridge_reset_clock
	import brc_pkg::*;
#(
	parameter int DLY_W = BRC_DLY_FIELD_W,
	// Calibration value, arbitrary default
	parameter logic [7:0] CAL_VALUE = 8'h10
)(
	// Clock, reset, enable
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	input wire logic CE_I,
	// Board reset inputs
	input wire logic PWR_GOOD_I,
	input wire logic RESET_N_I,
	// Straps, index is bridge
	input wire logic [1:0][1:0] CAP_SENSE_I,
	input wire logic [1:0] M66_SENSE_I,
	input wire logic [1:0][1:0] GNT_STRAP_I,
	// Hot plug serial pin
	input wire logic HP_SDATA_I,
	output logic HP_SDATA_O,
	output logic HP_SDATA_OE_O,
	input wire logic HP_SHIFT_DATA_I,
	// Register port
	input wire logic [BRC_AW-1:0] REG_ADDR_I,
	input wire logic [BRC_DW-1:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [BRC_DW-1:0] REG_RDATA_O,
	// Reset status
	output logic COLD_RST_O,
	output logic WARM_RST_O,
	output logic [1:0] LINK_INIT_O,
	// Bridge outputs
	output logic [1:0][4:0] BUS_MODE_O,
	output logic [1:0][4:0] RGC_SET_EN_O,
	output logic [1:0] SLOT_FORCE_LOW_O,
	output logic [1:0] SEC_CLK_TICK_O,
	output logic [1:0] PLL_FB_TICK_O,
	// Link rate settings
	output logic [3:0] LINK_RATE_A_O,
	output logic [3:0] LINK_RATE_B_O
);
	if (DLY_W < 1 || DLY_W > BRC_DLY_FIELD_W)
	begin : g_chk
		$error("DLY_W does not fit the control word");
	end

	logic pg_ok;
	brc_state_t state_ff;
	brc_state_t nxt_state;
	logic [4:0] strap_ff [BRC_NB];
	logic hp_strap_ff;
	logic hpb_en_ff;
	logic [3:0] lra_ff;
	logic [3:0] lrb_ff;
	brc_mode_t mode_ff [BRC_NB];
	logic [DLY_W-1:0] sdly_ff [BRC_NB];
	logic [DLY_W-1:0] fdly_ff [BRC_NB];
	logic [BRC_NB-1:0] sss_ff;
	logic [BRC_NB-1:0] pwr_ff;
	logic [1:0] link_init_ff;
	logic [BRC_DW-1:0] rdata_ff;
	logic [BRC_DW-1:0] stat_word [BRC_NB];
	logic [BRC_DW-1:0] glob_word;
	wire [BRC_NB-1:0] hp = {hpb_en_ff, hp_strap_ff};
	wire in_rst = (state_ff != BRC_ST_RUN);
	wire wr_glob = REG_WR_I && (REG_ADDR_I == BRC_OFS_GLOBAL);

	// Unmapped addresses read as zero; set-mode fields read as zero
	wire [BRC_DW-1:0] ctrl_word0 = {16'h0, 5'h00, 1'b0, pwr_ff[0],
		sss_ff[0], 4'(fdly_ff[0]), 4'(sdly_ff[0])};
	wire [BRC_DW-1:0] ctrl_word1 = {16'h0, 5'h00, 1'b0, pwr_ff[1],
		sss_ff[1], 4'(fdly_ff[1]), 4'(sdly_ff[1])};
	wire [BRC_DW-1:0] rd_sel = (REG_ADDR_I == BRC_OFS_CTRL_A) ? ctrl_word0 :
		(REG_ADDR_I == BRC_OFS_CTRL_B) ? ctrl_word1 :
		(REG_ADDR_I == BRC_OFS_STAT_A) ? stat_word[0] :
		(REG_ADDR_I == BRC_OFS_STAT_B) ? stat_word[1] :
		(REG_ADDR_I == BRC_OFS_GLOBAL) ? glob_word : '0;

	brc_deglitch #(
		.STABLE(BRC_PG_STABLE_CYC)
	) u_pg (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.ce_i(CE_I),
		.d_i(PWR_GOOD_I),
		.q_o(pg_ok)
	);

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			BRC_ST_COLD: nxt_state = !pg_ok ? BRC_ST_COLD :
				(RESET_N_I ? BRC_ST_RUN : BRC_ST_WARM);
			BRC_ST_WARM: nxt_state = !pg_ok ? BRC_ST_COLD :
				(RESET_N_I ? BRC_ST_RUN : BRC_ST_WARM);
			BRC_ST_RUN: nxt_state = !pg_ok ? BRC_ST_COLD :
				(RESET_N_I ? BRC_ST_RUN : BRC_ST_WARM);
			default: nxt_state = BRC_ST_COLD;
		endcase
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			state_ff <= BRC_ST_COLD;
			link_init_ff <= 2'h0;
			hp_strap_ff <= 1'b0;
			hpb_en_ff <= 1'b0;
			lra_ff <= BRC_RST_LRATE;
			lrb_ff <= BRC_RST_LRATE;
			rdata_ff <= '0;
		end
		else if (CE_I)
		begin
			state_ff <= nxt_state;
			link_init_ff <= {2{in_rst && (nxt_state == BRC_ST_RUN)}};
			// hot plug strap from serial pin
			if (!pg_ok)
				hp_strap_ff <= HP_SDATA_I;
			if (wr_glob)
			begin
				hpb_en_ff <= REG_WDATA_I[BRC_GL_HPB_EN];
				lra_ff <= REG_WDATA_I[BRC_GL_LRA_LSB +: 4];
				lrb_ff <= REG_WDATA_I[BRC_GL_LRB_LSB +: 4];
			end
			rdata_ff <= REG_RD_I ? rd_sel : '0;
		end
	end

	// Serial pin is input only while the deglitched power good is low
	assign HP_SDATA_OE_O = pg_ok;
	assign HP_SDATA_O = (|hp) ? HP_SHIFT_DATA_I : 1'b0;

	for (genvar i = 0; i < BRC_NB; i++)
	begin : g_br
		localparam logic [4:0] CT_OFS = (i == 0) ? BRC_OFS_CTRL_A :
			BRC_OFS_CTRL_B;
		wire [1:0] cap = strap_ff[i][4:3];
		wire m66 = strap_ff[i][2];
		wire [1:0] gnt = strap_ff[i][1:0];
		wire wr_ctrl = REG_WR_I && (REG_ADDR_I == CT_OFS);
		wire [4:0] req_mode = REG_WDATA_I[BRC_CT_MODE_LSB +: 5];
		wire req_ok = (req_mode != 5'h00) &&
			((req_mode & (req_mode - 5'h01)) == 5'h00);
		wire conv66 = (cap == BRC_CAP_GND) && m66;
		brc_mode_t strap_mode;
		brc_mode_t nxt_mode;
		logic [BRC_NCO_W:0] s_sum;
		logic [BRC_NCO_W:0] f_sum;
		logic [BRC_NCO_W-1:0] sacc_ff;
		logic [BRC_NCO_W-1:0] facc_ff;
		logic s_tick_ff;
		logic f_tick_ff;
		logic [BRC_NCO_W-1:0] inc;

		assign strap_mode = (cap == BRC_CAP_GND) ?
			(m66 ? BRC_M_C66 : BRC_M_C33) :
			(cap == BRC_CAP_MID) ? BRC_M_X66 :
			((gnt == BRC_GNT_133) ? BRC_M_X133 : BRC_M_X100);

		// hot plug forced to 33 in reset
		assign nxt_mode = in_rst ? (hp[i] ? BRC_M_C33 : strap_mode) :
			(wr_ctrl && REG_WDATA_I[BRC_CT_SET] && hp[i] && req_ok) ?
			brc_mode_t'(req_mode) : mode_ff[i];

		assign inc = (mode_ff[i] == BRC_M_C33) ? BRC_INC_33 :
			(mode_ff[i] == BRC_M_X100) ? BRC_INC_100 :
			(mode_ff[i] == BRC_M_X133) ? BRC_INC_133 : BRC_INC_66;
		assign s_sum = {1'b0, sacc_ff} + {1'b0, inc};
		assign f_sum = {1'b0, facc_ff} + {1'b0, BRC_INC_FB};

		always_ff @(posedge MCLK_I or negedge RST_N_I)
		begin
			if (!RST_N_I)
			begin
				strap_ff[i] <= BRC_RST_STRAP;
				mode_ff[i] <= BRC_M_C33;
				sdly_ff[i] <= DLY_W'(BRC_RST_DLY);
				fdly_ff[i] <= DLY_W'(BRC_RST_DLY);
				sss_ff[i] <= 1'b0;
				pwr_ff[i] <= 1'b0;
				sacc_ff <= '0;
				facc_ff <= '0;
				s_tick_ff <= 1'b0;
				f_tick_ff <= 1'b0;
				RGC_SET_EN_O[i] <= BRC_SETS_5;
				SLOT_FORCE_LOW_O[i] <= 1'b0;
			end
			else if (CE_I)
			begin
				if (!pg_ok)
					strap_ff[i] <= {CAP_SENSE_I[i], M66_SENSE_I[i],
						GNT_STRAP_I[i]};
				mode_ff[i] <= nxt_mode;
				if (wr_ctrl)
				begin
					sdly_ff[i] <= REG_WDATA_I[BRC_CT_SDLY_LSB +: DLY_W];
					fdly_ff[i] <= REG_WDATA_I[BRC_CT_FDLY_LSB +: DLY_W];
					sss_ff[i] <= REG_WDATA_I[BRC_CT_SSS];
					pwr_ff[i] <= REG_WDATA_I[BRC_CT_PWR];
				end
				sacc_ff <= s_sum[BRC_NCO_W-1:0];
				facc_ff <= f_sum[BRC_NCO_W-1:0];
				s_tick_ff <= s_sum[BRC_NCO_W];
				f_tick_ff <= f_sum[BRC_NCO_W];
				RGC_SET_EN_O[i] <= (mode_ff[i] == BRC_M_C33) ? BRC_SETS_5 :
					(mode_ff[i] == BRC_M_X133) ? BRC_SETS_3 : BRC_SETS_4;
				SLOT_FORCE_LOW_O[i] <= hp[i] && sss_ff[i] && !pwr_ff[i];
			end
		end

		brc_tick_delay #(
			.W(DLY_W)
		) u_sdly (
			.clk_i(MCLK_I),
			.rst_n_i(RST_N_I),
			.ce_i(CE_I),
			.sel_i(sdly_ff[i]),
			.d_i(s_tick_ff),
			.q_o(SEC_CLK_TICK_O[i])
		);
		brc_tick_delay #(
			.W(DLY_W)
		) u_fdly (
			.clk_i(MCLK_I),
			.rst_n_i(RST_N_I),
			.ce_i(CE_I),
			.sel_i(fdly_ff[i]),
			.d_i(f_tick_ff),
			.q_o(PLL_FB_TICK_O[i])
		);

		always_comb
		begin
			stat_word[i] = '0;
			stat_word[i][BRC_ST_SCF_LSB +: 5] = strap_ff[i];
			stat_word[i][BRC_ST_CONV66] = conv66;
			stat_word[i][BRC_ST_HP] = hp[i];
			stat_word[i][BRC_ST_MODE_LSB +: 5] = mode_ff[i];
			stat_word[i][BRC_ST_INRST] = in_rst;
		end

		assign BUS_MODE_O[i] = mode_ff[i];

		AST_HP_FORCE: assert property (@(posedge MCLK_I) disable iff (!RST_N_I || !CE_I) in_rst && hp[i] |=> mode_ff[i] == BRC_M_C33) else $error("hot plug bridge not forced");
		AST_SETS_133: assert property (@(posedge MCLK_I) disable iff (!RST_N_I || !CE_I) mode_ff[i] == BRC_M_X133 |=> RGC_SET_EN_O[i] == BRC_SETS_3) else $error("wrong set mask at 133");
		AST_SLOT_LOW: assert property (@(posedge MCLK_I) disable iff (!RST_N_I || !CE_I) hp[i] && sss_ff[i] && !pwr_ff[i] |=> SLOT_FORCE_LOW_O[i]) else $error("slot not forced low");
		AST_STRAP_HOLD: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) pg_ok |=> $stable(strap_ff[i])) else $error("strap changed after power good");
		AST_CONV33: assert property (@(posedge MCLK_I) disable iff (!RST_N_I || !CE_I) in_rst && !hp[i] && cap == BRC_CAP_GND && !m66 |=> mode_ff[i] == BRC_M_C33) else $error("grounded strap not 33");
		AST_X133: assert property (@(posedge MCLK_I) disable iff (!RST_N_I || !CE_I) in_rst && !hp[i] && cap[1] && gnt == BRC_GNT_133 |=> mode_ff[i] == BRC_M_X133) else $error("pullup strap not 133");
	end

	always_comb
	begin
		glob_word = '0;
		glob_word[BRC_GL_CAL_LSB +: 8] = CAL_VALUE;
		glob_word[BRC_GL_HPSTRAP] = hp_strap_ff;
		glob_word[BRC_GL_HPB_EN] = hpb_en_ff;
		glob_word[BRC_GL_LRA_LSB +: 4] = lra_ff;
		glob_word[BRC_GL_LRB_LSB +: 4] = lrb_ff;
	end

	assign REG_RDATA_O = rdata_ff;
	assign COLD_RST_O = (state_ff == BRC_ST_COLD);
	assign WARM_RST_O = (state_ff == BRC_ST_WARM);
	assign LINK_INIT_O = link_init_ff;
	assign LINK_RATE_A_O = lra_ff;
	assign LINK_RATE_B_O = lrb_ff;

	AST_COLD: assert property (@(posedge MCLK_I) disable iff (!RST_N_I || !CE_I) !pg_ok |=> COLD_RST_O && !WARM_RST_O) else $error("cold reset missed");
	AST_WARM: assert property (@(posedge MCLK_I) disable iff (!RST_N_I || !CE_I) pg_ok && !RESET_N_I |=> WARM_RST_O && !COLD_RST_O) else $error("warm reset missed");
	AST_LINK_INIT: assert property (@(posedge MCLK_I) disable iff (!RST_N_I || !CE_I) in_rst && nxt_state == BRC_ST_RUN |=> LINK_INIT_O == 2'h3 ##1 LINK_INIT_O == 2'h0) else $error("link start not one pulse");
	AST_HP_PIN: assert property (@(posedge MCLK_I) disable iff (!RST_N_I || !CE_I) !PWR_GOOD_I |=> !HP_SDATA_OE_O) else $error("serial pin driven during strap");
endmodule

//--- brc_board_model.sv
module brc_board_model #(
	// Stands for the 1 ms holds, shortened for run time
	parameter int HOLD = 30
)(
	input wire logic clk_i,
	input wire logic oe_i,
	input wire logic dout_i,
	input wire logic hp_strap_i,
	output logic pg_o,
	output logic rst_n_o,
	output wire logic pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// weak strap resistor wins when pin undriven
	assign pin_o = oe_i ? dout_i : hp_strap_i;
	initial
	begin
		pg_o = 1'b0;
		rst_n_o = 1'b0;
	end
	// both low, then reset held after power good
	task automatic cold();
		@(posedge clk_i);
		pg_o <= 1'b0;
		rst_n_o <= 1'b0;
		repeat (HOLD) @(posedge clk_i);
		pg_o <= 1'b1;
		repeat (HOLD) @(posedge clk_i);
		rst_n_o <= 1'b1;
	endtask
	// warm reset held the minimum time
	task automatic warm();
		@(posedge clk_i);
		rst_n_o <= 1'b0;
		repeat (HOLD) @(posedge clk_i);
		rst_n_o <= 1'b1;
	endtask
	// Short power good pulse, for the deglitcher
	task automatic glitch(input int n);
		@(posedge clk_i);
		pg_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		pg_o <= 1'b0;
	endtask
endmodule

//--- brc_bridge_reset_clock_tb_top.sv
module brc_bridge_reset_clock_tb_top
	import brc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, pg, brn, sdo, oe, sh, hps, wr, rd, cold, warm, ce;
	wire logic pin;
	logic [1:0][1:0] cap, gnt;
	logic [1:0] m66, li, slo, stk, ftk;
	logic [4:0] ad;
	logic [31:0] wd, rdat, v;
	logic [1:0][4:0] md, sets;
	logic [3:0] lra, lrb;
	int n_fail, checks, cyc, n, nf, d0, d1;
	logic [1:0] t_cap[5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
	logic t_m66[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	logic [1:0] t_gnt[5] = '{2'h3, 2'h0, 2'h0, 2'h1, 2'h0};
	brc_mode_t t_md[5] = '{BRC_M_C33, BRC_M_C66, BRC_M_X66, BRC_M_X100,
		BRC_M_X133};
	logic [4:0] t_set[5] = '{BRC_SETS_5, BRC_SETS_4, BRC_SETS_4,
		BRC_SETS_4, BRC_SETS_3};
	int t_cnt[5] = '{100, 200, 200, 300, 400};

	brc_bridge_reset_clock dut (
		.MCLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
		.PWR_GOOD_I(pg), .RESET_N_I(brn), .CAP_SENSE_I(cap),
		.M66_SENSE_I(m66), .GNT_STRAP_I(gnt), .HP_SDATA_I(pin),
		.HP_SDATA_O(sdo), .HP_SDATA_OE_O(oe), .HP_SHIFT_DATA_I(sh),
		.REG_ADDR_I(ad), .REG_WDATA_I(wd), .REG_WR_I(wr),
		.REG_RD_I(rd), .REG_RDATA_O(rdat), .COLD_RST_O(cold),
		.WARM_RST_O(warm), .LINK_INIT_O(li), .BUS_MODE_O(md),
		.RGC_SET_EN_O(sets), .SLOT_FORCE_LOW_O(slo),
		.SEC_CLK_TICK_O(stk), .PLL_FB_TICK_O(ftk),
		.LINK_RATE_A_O(lra), .LINK_RATE_B_O(lrb));
	brc_board_model #(.HOLD(30)) bm (.clk_i(clk), .oe_i(oe),
		.dout_i(sdo), .hp_strap_i(hps), .pg_o(pg), .rst_n_o(brn),
		.pin_o(pin));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic stop_test();
		if (n_fail == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			stop_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, e);
		checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		ad <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk);
		ad <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdat;
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic wait_init();
		for (int k = 0; k < 40 && li !== 2'b11; k++) tick();
		chk("link init", li, 2'b11);
		tick();
		chk("init pulse", li, 2'b00);
	endtask
	// Cycles from a tick of bridge r to the next tick of the other
	task automatic meas(input bit fb, input int r, output int d);
		logic [1:0] t;
		d = 99;
		for (int k = 0; k < 20; k++)
		begin
			tick();
			t = fb ? ftk : stk;
			if (t[r])
				break;
		end
		for (int k = 0; k < 8; k++)
		begin
			if (t[1-r])
			begin
				d = k;
				break;
			end
			tick();
			t = fb ? ftk : stk;
		end
	endtask
	task automatic glitch_try(input int len, input logic exp);
		logic seen;
		seen = 1'b0;
		fork
			bm.glitch(len);
			repeat (12)
			begin
				tick();
				seen |= oe;
			end
		join
		chk("deglitch", seen, exp);
	endtask

	initial
	begin
		{rst_n, sh, hps, wr, rd, cap, gnt, m66, ad, wd} = '0;
		sh = 1'b1;
		ce = 1'b1;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		glitch_try(6, 1'b0);
		glitch_try(7, 1'b1);
		chk("cold", {cold, warm}, 2'b10);
		for (int i = 0; i < 5; i++)
		begin
			cap <= {t_cap[i], t_cap[i]};
			m66 <= {t_m66[i], t_m66[i]};
			gnt <= {t_gnt[i], t_gnt[i]};
			bm.cold();
			wait_init();
			for (int b = 0; b < 2; b++)
			begin
				chk("mode", md[b], t_md[i]);
				chk("sets", sets[b], t_set[i]);
				rd_reg(b ? BRC_OFS_STAT_B : BRC_OFS_STAT_A, v);
				chk("status", v, {16'h0, 1'b0, t_md[i], 1'b0,
					t_md[i] == BRC_M_C66, 3'h0, t_cap[i], t_m66[i],
					t_gnt[i]});
			end
			{n, nf} = '0;
			repeat (600)
			begin
				tick();
				n += stk[0];
				nf += ftk[0];
			end
			chk("bus rate", n >= t_cnt[i] - 1 && n <= t_cnt[i] + 1, 1);
			chk("fb rate", nf >= 197 && nf <= 199, 1);
			if (i == 0)
			begin
				chk("pin low", pin, 1'b0);
				meas(0, 1, d0);
				// rounded step count, other field left zero
				wr_reg(BRC_OFS_CTRL_A, (156 * 16 + 625) / 1250);
				meas(0, 1, d1);
				chk("bus delay", d1, d0 + 2);
				meas(1, 0, d0);
				wr_reg(BRC_OFS_CTRL_B, 32'h10);
				meas(1, 0, d1);
				chk("fb delay", d1, d0 + 1);
			end
		end
		cap <= '0;
		gnt <= '1;
		repeat (20) tick();
		chk("held", md[0], BRC_M_X133);
		fork
			bm.warm();
			begin
				repeat (5) tick();
				chk("warm", {cold, warm}, 2'b01);
			end
		join
		wait_init();
		chk("kept", md[0], BRC_M_X133);
		cap <= {2'h3, 2'h3};
		gnt <= '0;
		hps <= 1'b1;
		bm.cold();
		wait_init();
		chk("hp forced", md[0], BRC_M_C33);
		chk("hp other", md[1], BRC_M_X133);
		// Strap resistor removed, so only the drive can hold the pin high
		hps <= 1'b0;
		tick();
		chk("pin drive", pin, 1'b1);
		wr_reg(BRC_OFS_GLOBAL, {14'h0, 4'h9, 4'h5, 2'h0, 8'h00});
		rd_reg(BRC_OFS_GLOBAL, v);
		chk("global", v, {14'h0, 4'h9, 4'h5, 2'h1, 8'h10});
		chk("rate a", lra, 4'h5);
		chk("rate b", lrb, 4'h9);
		rd_reg(5'h14, v);
		chk("unmapped", v, 32'h0);
		wr_reg(BRC_OFS_CTRL_A, 32'h100);
		tick();
		chk("slot low", slo[0], 1'b1);
		wr_reg(BRC_OFS_CTRL_A, 32'h300);
		tick();
		chk("slot pwr", slo[0], 1'b0);
		wr_reg(BRC_OFS_CTRL_A, 32'h8700);
		repeat (3) tick();
		chk("set mode", md[0], BRC_M_X133);
		rd_reg(BRC_OFS_CTRL_A, v);
		chk("ctrl", v, 32'h300);
		// Write while the enable is low must be lost
		ce <= 1'b0;
		wr_reg(BRC_OFS_CTRL_A, 32'h0);
		ce <= 1'b1;
		rd_reg(BRC_OFS_CTRL_A, v);
		chk("frozen", v, 32'h300);
		bm.warm();
		wait_init();
		chk("hp warm", md[0], BRC_M_C33);
		chk("b warm", md[1], BRC_M_X133);
		stop_test();
	end
endmodule
